/* core/cos_overflow_status.sv */
// overflow flags, interrupt enables and monitor request for a counter set
// ------------------------------------------------------------
// ------------------------------------------------------------
//
// Added by the designer: the Wishbone interface to the registers and the register offsets.
`timescale 1ns/1ps
`include "cos_params.svh"

module cos_overflow_status (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [5:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [31:0] cycleCounter,
    input wire logic [127:0] eventCounters,
    input wire logic [3:0] chainPairs,
    input wire logic freezeWhenWrapped,
    output logic countFreeze,
    output logic monitorReqSecure,
    output logic monitorReqNonSecure,
    output logic irq
);
    localparam int NEVT = `COS_NUM_EVT;
    // flags of counters that do not exist read as zero and ignore writes
    localparam logic [31:0] IMPL_MASK = 32'h8000_0000 | ((32'h1 << NEVT) - 32'h1);

    typedef struct packed {
        logic [31:0] flags;
        logic [31:0] irqEnable;
        logic [1:0] ctrl;
        logic [1:0] irqStat;
        logic [1:0] irqMask;
        logic [31:0] rdData;
        logic monSec;
        logic monNs;
        logic freeze;
        logic irqOut;
    } cos_state_s;

    cos_state_s state_ff;
    cos_state_s nxt_state;
    logic wrStrobe;
    logic rdStrobe;
    logic [5:0] accAddr;
    logic [31:0] wrData;
    logic ackInt;
    logic cycWrap;
    logic [NEVT-1:0] evtWrapRaw;
    logic [31:0] wrapVec;
    logic monReq;

    // ------------------------------------------------------------
    // bus front end
    // ------------------------------------------------------------
    cos_wb_slave u_bus (
        .clk_sys(clk_sys),
        .reset(reset),
        .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i),
        .wb_ack_o(ackInt),
        .wrStrobe(wrStrobe),
        .rdStrobe(rdStrobe),
        .accAddr(accAddr),
        .wrData(wrData)
    );

    // ------------------------------------------------------------
    // wrap detection for every counter
    // ------------------------------------------------------------
    cos_wrap_detect #(.WIDTH(32)) u_cyc (
        .clk_sys(clk_sys),
        .reset(reset),
        .countValue(cycleCounter),
        .wrapPulse(cycWrap)
    );

    genvar gi;
    generate
        for (gi = 0; gi < NEVT; gi++) begin : g_evt
            cos_wrap_detect #(.WIDTH(16)) u_evt (
                .clk_sys(clk_sys),
                .reset(reset),
                .countValue(eventCounters[gi*16 +: 16]),
                .wrapPulse(evtWrapRaw[gi])
            );
        end
    endgenerate

    // a chained pair wraps as one 32-bit counter: the even half carries into
    // the odd one, so only the odd counter's wrap marks the pair
    always_comb begin
        wrapVec = '0;
        for (int i = 0; i < NEVT; i++) begin
            if ((i % 2 == 0) && chainPairs[i/2]) begin
                wrapVec[i] = 1'b0;
            end else begin
                wrapVec[i] = evtWrapRaw[i];
            end
        end
        wrapVec[`COS_CYC_BIT] = cycWrap;
    end

    // decoded register hit, used for both read and write paths
    function automatic logic hit(input logic [5:0] a, input logic [5:0] ofs);
        hit = (a == ofs);
    endfunction

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        nxt_state = state_ff;
        // software writes first, then hardware sets on top so a wrap wins
        if (wrStrobe) begin
            if (hit(accAddr, `COS_OFS_SET_VIEW)) begin
                nxt_state.flags = state_ff.flags | (wrData & IMPL_MASK);
            end
            if (hit(accAddr, `COS_OFS_CLR_VIEW)) begin
                nxt_state.flags = state_ff.flags & ~wrData;
            end
            if (hit(accAddr, `COS_OFS_IEN_SET)) begin
                nxt_state.irqEnable = state_ff.irqEnable | (wrData & IMPL_MASK);
            end
            if (hit(accAddr, `COS_OFS_IEN_CLR)) begin
                nxt_state.irqEnable = state_ff.irqEnable & ~wrData;
            end
            if (hit(accAddr, `COS_OFS_CTRL)) begin
                nxt_state.ctrl = wrData[1:0];
            end
            if (hit(accAddr, `COS_OFS_IRQ_MASK)) begin
                nxt_state.irqMask = wrData[1:0];
            end
        end
        // reading status clears it; a new event in the same cycle survives
        if (rdStrobe && hit(accAddr, `COS_OFS_IRQ_STAT)) begin
            nxt_state.irqStat = '0;
        end
        // flag is a single bit, extra wraps simply or into it
        nxt_state.flags = nxt_state.flags | wrapVec;
        nxt_state.irqStat[`COS_IRQ_WRAP_BIT] = nxt_state.irqStat[`COS_IRQ_WRAP_BIT] | (|wrapVec);
        nxt_state.irqStat[`COS_IRQ_MON_BIT] = nxt_state.irqStat[`COS_IRQ_MON_BIT]
            | (monReq & ~state_ff.monSec & ~state_ff.monNs);
        // request level only while monitor mode is on; no halt is requested
        nxt_state.monSec = monReq & state_ff.ctrl[`COS_CTRL_SEC_BIT];
        nxt_state.monNs = monReq & ~state_ff.ctrl[`COS_CTRL_SEC_BIT];
        // freeze holds until software clears every flag or drops the control
        nxt_state.freeze = freezeWhenWrapped & (|nxt_state.flags);
        nxt_state.irqOut = |(nxt_state.irqStat & nxt_state.irqMask);
        // read mux, registered so data and ack line up
        nxt_state.rdData = '0;
        case (accAddr)
            `COS_OFS_SET_VIEW: nxt_state.rdData = state_ff.flags;
            `COS_OFS_CLR_VIEW: nxt_state.rdData = state_ff.flags;
            `COS_OFS_IEN_SET: nxt_state.rdData = state_ff.irqEnable;
            `COS_OFS_IEN_CLR: nxt_state.rdData = state_ff.irqEnable;
            `COS_OFS_CTRL: nxt_state.rdData = {30'h0, state_ff.ctrl};
            `COS_OFS_IRQ_STAT: nxt_state.rdData = {30'h0, state_ff.irqStat};
            `COS_OFS_IRQ_MASK: nxt_state.rdData = {30'h0, state_ff.irqMask};
            default: nxt_state.rdData = '0;
        endcase
    end

    // monitor request: any flag whose enable is set, with monitor mode on
    assign monReq = (|(state_ff.flags & state_ff.irqEnable))
        & state_ff.ctrl[`COS_CTRL_MONITOR_MODE_ENABLE_BIT];

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            state_ff.flags <= `COS_FLAGS_RST;
            state_ff.irqEnable <= `COS_IEN_RST;
            state_ff.ctrl <= `COS_CTRL_RST;
            state_ff.irqStat <= `COS_IRQ_RST;
            state_ff.irqMask <= `COS_IRQ_RST;
            state_ff.rdData <= 32'h0000_0000;
            state_ff.monSec <= 1'b0;
            state_ff.monNs <= 1'b0;
            state_ff.freeze <= 1'b0;
            state_ff.irqOut <= 1'b0;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    // read data is the value sampled one cycle before ack; address is held
    assign wb_dat_o = state_ff.rdData;
    assign wb_ack_o = ackInt;
    assign monitorReqSecure = state_ff.monSec;
    assign monitorReqNonSecure = state_ff.monNs;
    assign countFreeze = state_ff.freeze;
    assign irq = state_ff.irqOut;
endmodule // cos_overflow_status

/* core/cos_params.svh */
// constants for the counter overflow status block
`ifndef COS_PARAMS_SVH
`define COS_PARAMS_SVH

// ------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------
`define COS_OFS_SET_VIEW 6'h00
`define COS_OFS_CLR_VIEW 6'h04
`define COS_OFS_IEN_SET 6'h08
`define COS_OFS_IEN_CLR 6'h0c
`define COS_OFS_CTRL 6'h10
`define COS_OFS_IRQ_STAT 6'h14
`define COS_OFS_IRQ_MASK 6'h18

// ------------------------------------------------------------
// field positions and reset values
// ------------------------------------------------------------
`define COS_CYC_BIT 31
`define COS_NUM_EVT 8
`define COS_CTRL_MONITOR_MODE_ENABLE_BIT 0
`define COS_CTRL_SEC_BIT 1
`define COS_IRQ_MON_BIT 0
`define COS_IRQ_WRAP_BIT 1
`define COS_FLAGS_RST 32'h0000_0000
`define COS_IEN_RST 32'h0000_0000
`define COS_CTRL_RST 2'h0
`define COS_IRQ_RST 2'h0

`endif

/* core/cos_pkg.sv */
// types for the counter overflow status block
package cos_pkg;
    typedef logic [31:0] cos_word_t;
    typedef enum logic [1:0] {
        COS_IDLE = 2'b00,
        COS_ACK = 2'b01
    } cos_bus_e;
endpackage

/* core/cos_wb_slave.sv */
// classic wishbone slave front end: one-cycle ack, decoded strobes
`timescale 1ns/1ps
`include "cos_params.svh"

module cos_wb_slave (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [5:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic wb_ack_o,
    output logic wrStrobe,
    output logic rdStrobe,
    output logic [5:0] accAddr,
    output logic [31:0] wrData
);
    typedef struct packed {
        cos_pkg::cos_bus_e phase;
    } cos_wb_s;

    cos_wb_s state_ff;
    cos_wb_s nxt_state;
    logic req;

    // ------------------------------------------------------------
    // handshake
    // ------------------------------------------------------------
    // access acts in the cycle ack is raised so effect and ack coincide
    assign req = wb_cyc_i && wb_stb_i;

    always_comb begin
        nxt_state = state_ff;
        case (state_ff.phase)
            cos_pkg::COS_IDLE: if (req) nxt_state.phase = cos_pkg::COS_ACK;
            cos_pkg::COS_ACK: nxt_state.phase = cos_pkg::COS_IDLE;
            default: nxt_state.phase = cos_pkg::COS_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            state_ff.phase <= cos_pkg::COS_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // byte lanes zero unselected bytes of the write data; set and clear views ignore them, but ctrl and mask take the zeros
    // ack is decoded from the phase register alone; the master holds its request
    assign wb_ack_o = (state_ff.phase == cos_pkg::COS_ACK);
    assign wrStrobe = wb_ack_o && wb_we_i;
    assign rdStrobe = wb_ack_o && !wb_we_i;
    assign accAddr = wb_adr_i;
    assign wrData = wb_dat_i & {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                                {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
endmodule // cos_wb_slave

/* core/cos_wrap_detect.sv */
// wrap detector: one per counter, pulses when a counter rolls over
`timescale 1ns/1ps
`include "cos_params.svh"

module cos_wrap_detect #(
    parameter int WIDTH = 16
) (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic [WIDTH-1:0] countValue,
    output logic wrapPulse
);
    typedef struct packed {
        logic [WIDTH-1:0] last;
        logic seen;
    } cos_wd_s;

    cos_wd_s state_ff;
    cos_wd_s nxt_state;

    // ------------------------------------------------------------
    // wrap = all ones followed by zero
    // ------------------------------------------------------------
    // comparing with the held value avoids needing a separate increment strobe
    always_comb begin
        nxt_state = state_ff;
        nxt_state.last = countValue;
        nxt_state.seen = 1'b1;
    end

    assign wrapPulse = state_ff.seen && (&state_ff.last) && (countValue == '0);

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            state_ff <= '0;
        end else begin
            state_ff <= nxt_state;
        end
    end
endmodule // cos_wrap_detect

/* tb/cos_counter_model.sv */
// far side model: counters that wrap on request
`timescale 1ns/1ps
module cos_counter_model (
    input wire logic clk_sys,
    input wire logic [8:0] wrapReq,
    output logic [31:0] cycleCounter,
    output logic [127:0] eventCounters
);
    // a requested counter sits at all ones one cycle, then rolls to zero
    always @(posedge clk_sys) begin
        cycleCounter <= wrapReq[8] ? 32'hffff_ffff : 32'h0;
        for (int i = 0; i < 8; i++) begin
            eventCounters[16*i +: 16] <= wrapReq[i] ? 16'hffff : 16'h0;
        end
    end
endmodule // cos_counter_model

/* tb/cos_overflow_status_assertions.sv */
// port checker for the counter overflow status block
`timescale 1ns/1ps
module cos_overflow_status_assertions (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [5:0] wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic [31:0] cycleCounter,
    input wire logic freezeWhenWrapped,
    input wire logic countFreeze,
    input wire logic monitorReqSecure,
    input wire logic monitorReqNonSecure,
    input wire logic irq
);
    // one clock domain, so one default clocking and reset
    default clocking @(posedge clk_sys);
    endclocking
    default disable iff (reset);
    a_ack_once: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("request not answered next cycle");
    a_ack_cause: assert property (wb_ack_o |-> wb_cyc_i && wb_stb_i)
        else $error("ack without request");
    a_unmapped_zero: assert property (wb_ack_o && !wb_we_i && wb_adr_i > 6'h18
        |-> wb_dat_o == 32'h0) else $error("unmapped read not zero");
    a_route_excl: assert property (!(monitorReqSecure && monitorReqNonSecure))
        else $error("both monitor requests high");
    a_freeze_off: assert property (!freezeWhenWrapped |=> !countFreeze)
        else $error("freeze without freeze control");
    a_wrap_freeze: assert property (freezeWhenWrapped && cycleCounter == 32'hffff_ffff
        ##1 freezeWhenWrapped && cycleCounter == 32'h0 |-> ##[1:2] countFreeze)
        else $error("cycle wrap did not freeze");
    // reset itself must quiet every request, so no disable here
    a_reset_quiet: assert property (disable iff (1'b0) reset |=> !irq && !countFreeze
        && !monitorReqSecure && !monitorReqNonSecure) else $error("output live after reset");
    c_sec: cover property ($rose(monitorReqSecure));
    c_nsec: cover property ($rose(monitorReqNonSecure));
    c_irq: cover property ($rose(irq));
endmodule // cos_overflow_status_assertions

bind cos_overflow_status cos_overflow_status_assertions cos_overflow_status_assertions_inst (
    .clk_sys(clk_sys), .reset(reset), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .cycleCounter(cycleCounter), .freezeWhenWrapped(freezeWhenWrapped),
    .countFreeze(countFreeze), .monitorReqSecure(monitorReqSecure),
    .monitorReqNonSecure(monitorReqNonSecure), .irq(irq)
);

/* tb/cos_overflow_status_tb.sv */
// bench: wishbone stimulus, counter wraps and a reference model
`timescale 1ns/1ps
module cos_overflow_status_tb;
    localparam logic [31:0] VM = 32'h8000_00ff; // eight event flags and the cycle flag
    logic clk_sys, reset, cyc, we, ack, fz, frz, monS, monN, irq, lvl;
    logic [5:0] adr;
    logic [8:0] wrapReq;
    logic [3:0] chn;
    logic [31:0] dat, rd, cycCnt, seed, f, ien, ctrl, stat, mask;
    logic [127:0] evtCnt;
    int errorCnt, numChecks;

    cos_overflow_status cos_overflow_status_inst (
        .clk_sys(clk_sys), .reset(reset), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(rd), .wb_ack_o(ack),
        .cycleCounter(cycCnt), .eventCounters(evtCnt), .chainPairs(chn),
        .freezeWhenWrapped(fz), .countFreeze(frz), .monitorReqSecure(monS),
        .monitorReqNonSecure(monN), .irq(irq)
    );
    cos_counter_model cos_counter_model_inst (
        .clk_sys(clk_sys), .wrapReq(wrapReq), .cycleCounter(cycCnt), .eventCounters(evtCnt)
    );

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        numChecks++;
        if (got !== exp) begin
            errorCnt++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic endOfTest();
        $display("checks %0d errors %0d", numChecks, errorCnt);
        if (errorCnt == 0 && numChecks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // outputs lag flags by up to one edge, so wait four before looking
    task automatic settle();
        logic nl;
        nl = ctrl[0] && |(f & ien);
        if (nl && !lvl) stat[0] = 1'b1;
        lvl = nl;
        repeat (4) @(posedge clk_sys);
        chk({28'h0, irq, monS, monN, frz}, {28'h0, |(stat[1:0] & mask[1:0]),
            lvl && ctrl[1], lvl && !ctrl[1], fz && |f});
    endtask
    // one classic wishbone cycle, then the model follows the access
    task automatic acc(input logic w, input logic [5:0] a, input logic [31:0] d);
        int n;
        n = 0;
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        do begin
            @(posedge clk_sys);
            n++;
        end while (ack !== 1'b1 && n < 50);
        if (!w) chk(rd, a < 6'h08 ? f : a < 6'h10 ? ien : a == 6'h10 ? ctrl :
            a == 6'h14 ? stat : a == 6'h18 ? mask : 32'h0);
        cyc <= 1'b0;
        @(posedge clk_sys);
        if (!w && a == 6'h14) stat = 32'h0;
        if (w && a == 6'h00) f = f | (d & VM);
        if (w && a == 6'h04) f = f & ~d;
        if (w && a == 6'h08) ien = ien | (d & VM);
        if (w && a == 6'h0c) ien = ien & ~d;
        if (w && a == 6'h10) ctrl = d & 32'h3;
        if (w && a == 6'h18) mask = d & 32'h3;
        settle();
    endtask
    // counter i (8 is the cycle counter) wraps once
    task automatic wrap(input int i);
        wrapReq[i] <= 1'b1;
        @(posedge clk_sys);
        wrapReq <= 9'h0;
        repeat (3) @(posedge clk_sys);
        // a chained even counter only carries into its odd partner
        if (!(i < 8 && i % 2 == 0 && chn[i/2])) begin
            f = f | (i == 8 ? 32'h8000_0000 : 32'h1 << i);
            stat[1] = 1'b1;
        end
        settle();
    endtask

    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end
    // hang guard, far beyond the expected couple of thousand cycles
    initial begin
        repeat (8000) @(posedge clk_sys);
        errorCnt++;
        endOfTest();
    end
    initial begin
        {cyc, we, fz, adr, dat, wrapReq, chn} = '0;
        {f, ien, ctrl, stat, mask, lvl} = '0;
        seed = 32'h631a;
        errorCnt = 0;
        numChecks = 0;
        reset = 1'b1;
        repeat (16) @(posedge clk_sys);
        reset <= 1'b0;
        @(posedge clk_sys);
        for (int a = 0; a < 32; a += 4) begin
            acc(1'b0, 6'(a), 32'h0);
        end
        acc(1'b1, 6'h18, 32'h3);
        acc(1'b1, 6'h10, 32'h1);
        acc(1'b1, 6'h08, 32'h8000_0009);
        fz <= 1'b1;
        for (int i = 0; i < 9; i++) begin
            wrap(i);
            wrap(i);
            acc(1'b0, 6'h00, 32'h0);
            acc(1'b0, 6'h14, 32'h0);
            acc(1'b1, 6'h04, VM);
        end
        for (int k = 0; k < 40; k++) begin
            fz <= ^xs();
            acc(1'b1, 6'(4 * (xs() % 5)), xs());
            acc(1'b1, 6'h18, xs() & 32'h3);
            chn <= xs();
            wrap(xs() % 9);
            acc(1'b0, 6'(4 * (xs() % 8)), 32'h0);
        end
        // second reset in mid-run must clear flags and enables again
        reset <= 1'b1;
        repeat (2) @(posedge clk_sys);
        reset <= 1'b0;
        {f, ien, ctrl, stat, mask, lvl} = '0;
        @(posedge clk_sys);
        acc(1'b0, 6'h00, 32'h0);
        acc(1'b0, 6'h08, 32'h0);
        endOfTest();
    end
endmodule // cos_overflow_status_tb
